// ---- core/attn_flags.sv ----
// attenuator control, overload recovery and peak flags with wishbone regs
// intent and limitations
// - ack is registered, so at most one access every other cycle
// - a write lands on the acking edge, while the request still stands,
//   so a held request writes exactly once
// - reads are registered one edge early and stand while ack is high
// - the overload window is emptied after an event, so one burst
//   gives one recovery pulse and one attenuation step
// - a new event during the pulse restarts the pulse count
// - in mode 0 an overload step holds until the next reselect
// - the hold counter is 23 bits: mantissa shifted by up to 15
// - gain pins are taken as synchronous; no resynchroniser here
// - clock enable low freezes all state, ack included
// - reserved select codes give a low pin rather than a guess
//
// trade-offs
// - one packed state word keeps reset and freeze in one place
// - pin edges are found against the last enabled sample, so a
//   pulse that comes and goes while frozen is never seen
// - the status byte is built from live state, never stored
//
module attn_flags
    import attn_pkg::*;
(
    input  wire  logic        CORE_CLK,
    input  wire  logic        RESETN,
    input  wire  logic        CLK_EN,
    input  wire  logic [11:0] WB_ADR_I,
    input  wire  logic [31:0] WB_DAT_I,
    input  wire  logic [3:0]  WB_SEL_I,
    input  wire  logic        WB_WE_I,
    input  wire  logic        WB_CYC_I,
    input  wire  logic        WB_STB_I,
    output logic        [31:0] WB_DAT_O,
    output logic               WB_ACK_O,
    input  wire  logic        GAIN_PIN_1,
    input  wire  logic        GAIN_PIN_2,
    output logic               GAIN_PIN_3,
    input  wire  logic [4:0]  ADC_SAMPLE,
    input  wire  logic        ADC_VALID,
    output logic               ADC_RESET,
    input  wire  logic [11:0] DS_PEAK,
    input  wire  logic        DS_VALID,
    output logic        [4:0] ATTEN_CODE,
    output logic               ATTEN_ON
);

    ////////////////////////////////////////////////////////////////////////
    // state word

    typedef struct packed {
        // software storage
        logic [NUM_SLOTS-1:0][7:0] cfg;
        logic [1:0]                st_res;

        // attenuation path
        logic [4:0]                atten;
        logic                      atten_on;
        logic                      pin1_q;
        logic                      pin2_q;
        logic                      mode_q;

        // overload window and recovery pulse
        logic                      unstable;
        logic [7:0]                win;
        pulse_st_t                 pst;
        logic                      pulse;
        logic [7:0]                pcnt;

        // peak flags
        logic                      above_a;
        logic                      above_b;
        logic                      below;
        logic [DWELL_W-1:0]        dwell;
        logic                      pin3;

        // bus answer
        logic                      ack;
        logic [7:0]                dat;
    } state_t;

    // registered copy and its next value

    state_t s;
    state_t next_s;

    ////////////////////////////////////////////////////////////////////////
    // register decode

    logic [IDX_W-1:0]     idx;
    logic [NUM_SLOTS-1:0] slot_hit;
    logic                 bus_req;
    logic                 wr;

    // byte lanes above the first are ignored
    assign idx     = WB_ADR_I[11:2];

    // a request is taken once; ack blocks the second edge
    assign bus_req = WB_CYC_I & WB_STB_I & ~s.ack;

    // write on the acking edge, request still standing
    assign wr      = WB_CYC_I & WB_STB_I & s.ack & WB_WE_I & WB_SEL_I[0];

    // one compare per storage slot

    genvar g;
    generate
        for (g = 0; g < NUM_SLOTS; g++) begin : g_slot
            assign slot_hit[g] = (idx == SLOT_IDX[g]);
        end
    endgenerate

    // count of full-scale hits in the window
    // at most eight, so four bits suffice
    function automatic logic [3:0] ones8(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < WINDOW_LEN; i++) begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next state

    // assembled limits
    logic [11:0]        lim_a;
    logic [11:0]        lim_b;
    logic [11:0]        floor_lim;
    logic [DWELL_W-1:0] dwell_load;

    // overload detection
    logic               fs_hit;
    logic [7:0]         win_new;
    logic               overload;

    // attenuation stepping
    logic               mode1;
    logic               pin1_rise;
    logic               pin2_rise;
    logic [5:0]         sum;

    // pin 3 source
    logic               sel_flag;

    always_comb begin
        next_s = s;

        lim_a     = {s.cfg[SL_PA_HI][3:0], s.cfg[SL_PA_LO]};
        lim_b     = {s.cfg[SL_PB_HI][3:0], s.cfg[SL_PB_LO]};
        floor_lim = {s.cfg[SL_FL_HI][3:0], s.cfg[SL_FL_LO]};
        // hold time in decimated samples: mantissa shifted by exponent
        dwell_load = DWELL_W'({15'h0, s.cfg[SL_MANT]})
                     << s.cfg[SL_EXP][3:0];

        // bus slave: one wait state, ack drops the cycle after;
        // read data is latched at the taking edge
        next_s.ack = bus_req;

        // storage writes
        if (wr) begin
            for (int i = 0; i < NUM_SLOTS; i++) begin
                if (slot_hit[i]) begin
                    next_s.cfg[i] = WB_DAT_I[7:0];
                end
            end
            if (idx == IDX_STATUS) begin
                next_s.st_res = WB_DAT_I[6:5];
            end
        end

        // read mux; unmapped words read zero
        if (bus_req) begin
            next_s.dat = 8'h00;
            for (int i = 0; i < NUM_SLOTS; i++) begin
                if (slot_hit[i]) begin
                    next_s.dat = s.cfg[i];
                end
            end
            if (idx == IDX_STATUS) begin
                next_s.dat = {GAIN_PIN_2, s.st_res, s.atten};
            end
            if (idx == IDX_INSTAB) begin
                // clear bit always reads back zero
                next_s.dat = {7'h00, s.unstable};
            end
        end

        // overload window over the last eight samples
        fs_hit   = (ADC_SAMPLE == FULL_SCALE_P)
                 | (ADC_SAMPLE == FULL_SCALE_N);
        win_new  = {s.win[6:0], fs_hit};
        overload = 1'b0;
        if (ADC_VALID) begin
            overload = ones8(win_new) > {1'b0, s.cfg[SL_CNT][2:0]};
            // restart the window so one burst counts once
            next_s.win = overload ? 8'h00 : win_new;
        end

        // recovery pulse counted in sample periods; a new overload
        // during the pulse restarts it
        if (overload) begin
            next_s.pst  = PULSE_BUSY;
            next_s.pcnt = {s.cfg[SL_PULSE][4:0], PULSE_UNIT_M1};
        end else begin
            case (s.pst)
                PULSE_IDLE: begin
                    next_s.pst = PULSE_IDLE;
                end
                PULSE_BUSY: begin
                    if (ADC_VALID) begin
                        if (s.pcnt == 8'h00) begin
                            next_s.pst = PULSE_IDLE;
                        end else begin
                            next_s.pcnt = s.pcnt - 8'h01;
                        end
                    end
                end
                default: begin
                    next_s.pst = PULSE_IDLE;
                end
            endcase
        end
        next_s.pulse = (next_s.pst == PULSE_BUSY);

        // sticky flag: a set in the clearing cycle wins, so an
        // event is never lost to a clear racing it
        if (wr && idx == IDX_INSTAB && WB_DAT_I[UNST_CLR_BIT]) begin
            next_s.unstable = 1'b0;
        end
        if (overload) begin
            next_s.unstable = 1'b1;
        end


        // attenuation
        // mode follows the stored bit as written this edge, so
        // a mode write and its load happen together
        mode1          = next_s.cfg[SL_MODE][MODE_BIT];
        next_s.mode_q  = mode1;
        next_s.pin1_q  = GAIN_PIN_1;
        next_s.pin2_q  = GAIN_PIN_2;
        pin1_rise      = GAIN_PIN_1 & ~s.pin1_q;
        pin2_rise      = GAIN_PIN_2 & ~s.pin2_q;
        if (!mode1) begin
            // reselect only on a pin 2 change, a write or entry to this mode, so an
            // overload step is held until then
            if ((GAIN_PIN_2 != s.pin2_q) || s.mode_q ||
                (wr && (slot_hit[SL_PLOW] || slot_hit[SL_PHIGH]))) begin
                next_s.atten = GAIN_PIN_2
                             ? next_s.cfg[SL_PHIGH][4:0]
                             : next_s.cfg[SL_PLOW][4:0];
            end
        end else if (!s.mode_q || (wr && slot_hit[SL_START])) begin
            next_s.atten = next_s.cfg[SL_START][4:0];
        end else if (pin1_rise && !pin2_rise) begin
            if (s.atten != 5'h00) begin
                next_s.atten = s.atten - 5'h01;
            end
        end else if (pin2_rise && !pin1_rise) begin
            if (s.atten < ATTEN_MAX) begin
                next_s.atten = s.atten + 5'h01;
            end
        end

        // overload step comes after any pin step of the same edge;
        // six bits so the sum cannot wrap before the clip
        sum = {1'b0, next_s.atten} + {1'b0, s.cfg[SL_STEP][4:0]};
        if (overload) begin
            next_s.atten = (sum > {1'b0, ATTEN_MAX})
                         ? ATTEN_MAX : sum[4:0];
        end
        next_s.atten_on = (next_s.atten <= ATTEN_MAX);


        // decimated peak detection
        // flags move only on a decimated strobe and hold between;
        // the hold counter runs in decimated-sample periods
        if (DS_VALID) begin
            next_s.above_a = DS_PEAK > lim_a;
            next_s.above_b = DS_PEAK > lim_b;
            if (DS_PEAK >= floor_lim) begin
                next_s.dwell = dwell_load;
                next_s.below = 1'b0;
            end else if (s.dwell == '0) begin
                next_s.below = 1'b1;
            end else begin
                next_s.dwell = s.dwell - DWELL_W'(1);
            end
        end


        // pin 3 flag
        // taken from next values so the pin moves with its source
        case (s.cfg[SL_SEL][2:0])
            SEL_RESET_PULSE: sel_flag = next_s.pulse;
            SEL_ABOVE_A:     sel_flag = next_s.above_a;
            SEL_ABOVE_B:     sel_flag = next_s.above_b;
            SEL_BELOW_DWELL: sel_flag = next_s.below;
            default:         sel_flag = 1'b0;
        endcase
        next_s.pin3 = s.cfg[SL_EN][PIN3_EN_BIT] & sel_flag;
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    // reset only with constants; enable low holds every field
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            s          <= '0;
            s.cfg      <= SLOT_RESET;
            s.atten    <= ATTEN_RESET;
            s.atten_on <= 1'b1;
            s.pst      <= PULSE_IDLE;
        end else if (CLK_EN) begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, each straight from the state word

    assign WB_DAT_O   = {24'h00_0000, s.dat};
    assign WB_ACK_O   = s.ack;
    assign GAIN_PIN_3 = s.pin3;
    assign ADC_RESET  = s.pulse;
    assign ATTEN_CODE = s.atten;
    assign ATTEN_ON   = s.atten_on;

endmodule

// ---- include/attn_pkg.sv ----
// constants for the attenuator, overload and peak-flag block
package attn_pkg;
    // register word indexes; byte address is four times the index
    localparam int          IDX_W           = 10;
    localparam logic [9:0]  IDX_STEP_MODE   = 10'h180;
    localparam logic [9:0]  IDX_PIN_LOW_VAL = 10'h181;
    localparam logic [9:0]  IDX_PIN_HI_VAL  = 10'h182;
    localparam logic [9:0]  IDX_START       = 10'h183;
    localparam logic [9:0]  IDX_STATUS      = 10'h184;
    localparam logic [9:0]  IDX_CNT_LIMIT   = 10'h188;
    localparam logic [9:0]  IDX_PULSE_LEN   = 10'h189;
    localparam logic [9:0]  IDX_STEP        = 10'h18a;
    localparam logic [9:0]  IDX_INSTAB      = 10'h18f;
    localparam logic [9:0]  IDX_PA_LO       = 10'h193;
    localparam logic [9:0]  IDX_PA_HI       = 10'h194;
    localparam logic [9:0]  IDX_PB_LO       = 10'h195;
    localparam logic [9:0]  IDX_PB_HI       = 10'h196;
    localparam logic [9:0]  IDX_FL_LO       = 10'h197;
    localparam logic [9:0]  IDX_FL_HI       = 10'h198;
    localparam logic [9:0]  IDX_MANT        = 10'h199;
    localparam logic [9:0]  IDX_EXP         = 10'h19a;
    localparam logic [9:0]  IDX_SEL         = 10'h19b;
    localparam logic [9:0]  IDX_FLAG_EN     = 10'h19e;

    // plain read/write storage slots
    localparam int NUM_SLOTS = 17;
    localparam int SL_START  = 0;
    localparam int SL_CNT    = 1;
    localparam int SL_PULSE  = 2;
    localparam int SL_STEP   = 3;
    localparam int SL_PA_LO  = 4;
    localparam int SL_PA_HI  = 5;
    localparam int SL_PB_LO  = 6;
    localparam int SL_PB_HI  = 7;
    localparam int SL_FL_LO  = 8;
    localparam int SL_FL_HI  = 9;
    localparam int SL_MANT   = 10;
    localparam int SL_EXP    = 11;
    localparam int SL_SEL    = 12;
    localparam int SL_MODE   = 13;
    localparam int SL_PLOW   = 14;
    localparam int SL_PHIGH  = 15;
    localparam int SL_EN     = 16;

    localparam logic [NUM_SLOTS-1:0][9:0] SLOT_IDX = {
        IDX_FLAG_EN, IDX_PIN_HI_VAL, IDX_PIN_LOW_VAL, IDX_STEP_MODE,
        IDX_SEL, IDX_EXP, IDX_MANT, IDX_FL_HI, IDX_FL_LO, IDX_PB_HI,
        IDX_PB_LO, IDX_PA_HI, IDX_PA_LO, IDX_STEP, IDX_PULSE_LEN,
        IDX_CNT_LIMIT, IDX_START};
    localparam logic [NUM_SLOTS-1:0][7:0] SLOT_RESET = {
        8'h00, 8'h0c, 8'h0c, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h06, 8'h01, 8'h05, 8'h00};

    // field positions
    localparam int STATUS_PIN_BIT = 7;
    localparam int UNST_CLR_BIT   = 1;
    localparam int UNST_FLAG_BIT  = 0;
    localparam int MODE_BIT       = 0;
    localparam int PIN3_EN_BIT    = 0;

    localparam logic [4:0] ATTEN_RESET   = 5'h0c;
    localparam logic [4:0] ATTEN_MAX     = 5'h1b;
    localparam logic [4:0] FULL_SCALE_P  = 5'h08;
    localparam logic [4:0] FULL_SCALE_N  = 5'h18;
    localparam int         WINDOW_LEN    = 8;
    localparam logic [2:0] PULSE_UNIT_M1 = 3'h7;

    localparam logic [2:0] SEL_RESET_PULSE = 3'h0;
    localparam logic [2:0] SEL_ABOVE_A     = 3'h4;
    localparam logic [2:0] SEL_ABOVE_B     = 3'h5;
    localparam logic [2:0] SEL_BELOW_DWELL = 3'h6;

    localparam int DWELL_W = 23;

    typedef enum logic {
        PULSE_IDLE = 1'b0,
        PULSE_BUSY = 1'b1
    } pulse_st_t;
endpackage

// ---- tb/attn_flags_checker.sv ----
// port-level assertions for the attenuator and flag block
module attn_flags_checker (
    input  wire logic        CORE_CLK,
    input  wire logic        RESETN,
    input  wire logic        CLK_EN,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic [31:0] WB_DAT_O,
    input  wire logic        WB_ACK_O,
    input  wire logic        GAIN_PIN_1,
    input  wire logic        GAIN_PIN_2,
    input  wire logic        ADC_VALID,
    input  wire logic        ADC_RESET,
    input  wire logic [4:0]  ATTEN_CODE,
    input  wire logic        ATTEN_ON
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);
    logic [8:0] strobes;

    ////////////////////////////////////////////////////////////
    // strobes seen while the recovery pulse stands; restarts
    // inside a pulse are not modelled, so keep events apart
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN || !ADC_RESET)
            strobes <= 9'h000;
        else if (ADC_VALID)
            strobes <= strobes + 9'h001;
    end

    sequence s_req;
        WB_CYC_I && WB_STB_I && !WB_ACK_O && CLK_EN;
    endsequence
    sequence s_dn_floor;
        $rose(GAIN_PIN_1) && $stable(GAIN_PIN_2) && !GAIN_PIN_2 &&
        ATTEN_CODE == 5'h00 && !ADC_VALID && !(WB_CYC_I && WB_STB_I);
    endsequence
    property p_ack_next;
        s_req |=> WB_ACK_O;
    endproperty
    property p_ack_pulse;
        WB_ACK_O && CLK_EN |=> !WB_ACK_O;
    endproperty
    property p_dat_upper;
        WB_ACK_O |-> WB_DAT_O[31:8] == 24'h00_0000;
    endproperty
    property p_atten_on;
        ATTEN_ON == (ATTEN_CODE <= 5'h1b);
    endproperty
    property p_dn_floor;
        s_dn_floor |=> ATTEN_CODE == 5'h00;
    endproperty
    property p_step_sat;
        $rose(ADC_RESET) |-> ATTEN_ON && ATTEN_CODE <= 5'h1b;
    endproperty
    property p_pulse_start;
        $rose(ADC_RESET) |-> $past(ADC_VALID);
    endproperty
    property p_pulse_len;
        $fell(ADC_RESET) |-> $past(ADC_VALID) && strobes != 9'h000
            && strobes[2:0] == 3'h0;
    endproperty

    ////////////////////////////////////////////////////////////
    a_ack_next: assert property (p_ack_next)
        else $error("no ack after request");
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    a_dat_upper: assert property (p_dat_upper)
        else $error("read data upper bits set");
    a_atten_on: assert property (p_atten_on)
        else $error("attenuator enable wrong for code");
    a_dn_floor: assert property (p_dn_floor)
        else $error("decrement below zero");
    a_step_sat: assert property (p_step_sat)
        else $error("overload step not saturated");
    a_pulse_start: assert property (p_pulse_start)
        else $error("recovery pulse without sample");
    a_pulse_len: assert property (p_pulse_len)
        else $error("recovery pulse length not a multiple of 8");
endmodule

bind attn_flags attn_flags_checker attn_flags_checker_inst (
    .CORE_CLK(CORE_CLK), .RESETN(RESETN), .CLK_EN(CLK_EN),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .GAIN_PIN_1(GAIN_PIN_1),
    .GAIN_PIN_2(GAIN_PIN_2), .ADC_VALID(ADC_VALID),
    .ADC_RESET(ADC_RESET), .ATTEN_CODE(ATTEN_CODE), .ATTEN_ON(ATTEN_ON)
);

// ---- tb/attn_flags_tb.sv ----
// self-checking bench for the attenuator, overload and flag block
module attn_flags_tb
    import attn_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        CORE_CLK = 1'b0;
    logic        RESETN = 1'b0;
    logic [11:0] WB_ADR_I = 12'h000;
    logic [31:0] WB_DAT_I = 32'h0000_0000;
    logic        WB_WE_I = 1'b0, WB_CYC_I = 1'b0, WB_STB_I = 1'b0;
    logic [31:0] WB_DAT_O;
    logic        WB_ACK_O, GAIN_PIN_1, GAIN_PIN_2, GAIN_PIN_3;
    logic        ADC_RESET, ATTEN_ON, ADC_VALID = 1'b0, DS_VALID = 1'b0;
    logic        CLK_EN = 1'b1;
    logic [4:0]  ADC_SAMPLE = 5'h00, ATTEN_CODE;
    logic [11:0] DS_PEAK = 12'h000;
    logic        step_dn = 1'b0, step_up = 1'b0, level = 1'b0;
    logic [7:0]  rd;
    int          bad_count = 0, checks = 0;
    localparam logic [9:0] ridx [15] = '{IDX_START, IDX_STATUS,
        IDX_CNT_LIMIT, IDX_PULSE_LEN, IDX_STEP, IDX_INSTAB, IDX_PA_LO,
        IDX_PA_HI, IDX_PB_LO, IDX_PB_HI, IDX_FL_LO, IDX_FL_HI, IDX_MANT,
        IDX_EXP, IDX_SEL};
    localparam logic [7:0] rval [15] = '{8'h00, 8'h0c, 8'h05, 8'h01,
        8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00};
    // select code in the top nibble, decimated peak below it
    localparam logic [15:0] ftab [11] = '{16'h4124, 16'h4123, 16'h5457,
        16'h5456, 16'h6100, 16'h60ff, 16'h60ff, 16'h60ff, 16'h60ff,
        16'h60ff, 16'h6100};
    localparam logic [10:0] fexp = 11'h205;
    localparam logic [2:0] rsv [4] = '{3'h1, 3'h2, 3'h3, 3'h7};

    always #5 CORE_CLK = ~CORE_CLK;

    attn_flags attn_flags_inst (
        .CORE_CLK(CORE_CLK), .RESETN(RESETN), .CLK_EN(CLK_EN),
        .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_SEL_I(4'hf),
        .WB_WE_I(WB_WE_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
        .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
        .GAIN_PIN_1(GAIN_PIN_1), .GAIN_PIN_2(GAIN_PIN_2),
        .GAIN_PIN_3(GAIN_PIN_3), .ADC_SAMPLE(ADC_SAMPLE),
        .ADC_VALID(ADC_VALID), .ADC_RESET(ADC_RESET),
        .DS_PEAK(DS_PEAK), .DS_VALID(DS_VALID),
        .ATTEN_CODE(ATTEN_CODE), .ATTEN_ON(ATTEN_ON));
    gain_ctl_model gain_ctl_model_inst (
        .clk(CORE_CLK), .step_dn(step_dn), .step_up(step_up),
        .level(level), .pin_1(GAIN_PIN_1), .pin_2(GAIN_PIN_2));

    ////////////////////////////////////////////////////////////
    task automatic test_done;
        if (bad_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic [9:0] idx, input logic we,
                      input logic [7:0] d);
        int n;
        n = 0;
        @(posedge CORE_CLK);
        WB_ADR_I <= {idx, 2'b00};
        WB_WE_I <= we;
        WB_DAT_I <= {24'h00_0000, d};
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        do begin
            @(posedge CORE_CLK);
            n++;
        end while (WB_ACK_O !== 1'b1 && n < 20);
        if (n >= 20) begin
            bad_count++;
            $display("MISMATCH %0t bus timeout", $time);
            test_done();
        end
        rd = WB_DAT_O[7:0];
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
        WB_WE_I <= 1'b0;
    endtask
    task automatic rchk(input logic [9:0] idx, input logic [7:0] exp);
        wb(idx, 1'b0, 8'h00);
        chk(rd, exp);
    endtask
    task automatic pin(input logic dn, input logic up);
        @(posedge CORE_CLK);
        step_dn <= dn;
        step_up <= up;
        @(posedge CORE_CLK);
        step_dn <= 1'b0;
        step_up <= 1'b0;
        repeat (3) @(posedge CORE_CLK);
        #1;
    endtask
    task automatic adc(input logic [4:0] s, input int n);
        repeat (n) begin
            @(posedge CORE_CLK);
            ADC_SAMPLE <= s;
            ADC_VALID <= 1'b1;
            @(posedge CORE_CLK);
            ADC_VALID <= 1'b0;
        end
        #1;
    endtask
    task automatic ds(input logic [11:0] p);
        @(posedge CORE_CLK);
        DS_PEAK <= p;
        DS_VALID <= 1'b1;
        @(posedge CORE_CLK);
        DS_VALID <= 1'b0;
        #1;
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge CORE_CLK);
        RESETN <= 1'b1;
        for (int i = 0; i < 15; i++)
            rchk(ridx[i], rval[i]);
        for (int i = 6; i < 15; i++) begin
            wb(ridx[i], 1'b1, 8'ha5);
            rchk(ridx[i], 8'ha5);
            wb(ridx[i], 1'b1, 8'h00);
        end
        rchk(10'h185, 8'h00);
        wb(IDX_STATUS, 1'b1, 8'h9f);
        rchk(IDX_STATUS, 8'h0c);
        wb(IDX_START, 1'b1, 8'h01);
        wb(IDX_STEP_MODE, 1'b1, 8'h01);
        rchk(IDX_STATUS, 8'h01);
        pin(1'b1, 1'b0);
        chk({3'h0, ATTEN_CODE}, 8'h00);
        pin(1'b1, 1'b0);
        chk({3'h0, ATTEN_CODE}, 8'h00);
        wb(IDX_START, 1'b1, 8'h1b);
        pin(1'b0, 1'b1);
        chk({3'h0, ATTEN_CODE}, 8'h1b);
        pin(1'b1, 1'b0);
        chk({3'h0, ATTEN_CODE}, 8'h1a);
        // a pin pulse while frozen is never seen
        @(posedge CORE_CLK);
        CLK_EN <= 1'b0;
        pin(1'b1, 1'b0);
        chk({3'h0, ATTEN_CODE}, 8'h1a);
        @(posedge CORE_CLK);
        CLK_EN <= 1'b1;
        // overload with pin 3 showing the recovery pulse
        wb(IDX_START, 1'b1, 8'h10);
        wb(IDX_FLAG_EN, 1'b1, 8'h01);
        adc(5'h08, 5);
        chk({7'h00, ADC_RESET}, 8'h00);
        adc(5'h18, 1);
        chk({7'h00, ADC_RESET}, 8'h01);
        chk({7'h00, GAIN_PIN_3}, 8'h01);
        chk({3'h0, ATTEN_CODE}, 8'h16);
        rchk(IDX_INSTAB, 8'h01);
        adc(5'h00, 15);
        chk({7'h00, ADC_RESET}, 8'h01);
        adc(5'h00, 1);
        chk({7'h00, ADC_RESET}, 8'h00);
        chk({7'h00, GAIN_PIN_3}, 8'h00);
        wb(IDX_INSTAB, 1'b1, 8'h02);
        rchk(IDX_INSTAB, 8'h00);
        wb(IDX_FLAG_EN, 1'b1, 8'h00);
        wb(IDX_PULSE_LEN, 1'b1, 8'h00);
        adc(5'h08, 6);
        chk({3'h0, ATTEN_CODE}, 8'h1b);
        chk({7'h00, GAIN_PIN_3}, 8'h00);
        adc(5'h00, 7);
        chk({7'h00, ADC_RESET}, 8'h01);
        adc(5'h00, 1);
        chk({7'h00, ADC_RESET}, 8'h00);
        rchk(IDX_INSTAB, 8'h01);
        // stored-value mode, pin 2 high picks a disabling code
        wb(IDX_STEP_MODE, 1'b1, 8'h00);
        wb(IDX_PIN_HI_VAL, 1'b1, 8'h1d);
        @(posedge CORE_CLK);
        level <= 1'b1;
        repeat (3) @(posedge CORE_CLK);
        #1;
        chk({2'h0, ATTEN_ON, ATTEN_CODE}, 8'h1d);
        rchk(IDX_STATUS, 8'h9d);
        // peak flags: limit a 123, limit b 456, floor 100, hold 4
        wb(IDX_PA_LO, 1'b1, 8'h23);
        wb(IDX_PA_HI, 1'b1, 8'h01);
        wb(IDX_PB_LO, 1'b1, 8'h56);
        wb(IDX_PB_HI, 1'b1, 8'h04);
        wb(IDX_FL_HI, 1'b1, 8'h01);
        wb(IDX_MANT, 1'b1, 8'h02);
        wb(IDX_EXP, 1'b1, 8'h01);
        wb(IDX_FLAG_EN, 1'b1, 8'h01);
        for (int i = 0; i < 11; i++) begin
            wb(IDX_SEL, 1'b1, {4'h0, ftab[i][15:12]});
            ds(ftab[i][11:0]);
            chk({7'h00, GAIN_PIN_3}, {7'h00, fexp[i]});
        end
        for (int i = 0; i < 4; i++) begin
            wb(IDX_SEL, 1'b1, {5'h00, rsv[i]});
            ds(12'h500);
            chk({7'h00, GAIN_PIN_3}, 8'h00);
        end
        test_done();
    end
endmodule

// ---- tb/gain_ctl_model.sv ----
// external gain-control logic driving the two step pins
module gain_ctl_model (
    input  wire logic clk,
    input  wire logic step_dn,
    input  wire logic step_up,
    input  wire logic level,
    output logic      pin_1,
    output logic      pin_2
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        pin_1 = 1'b0;
        pin_2 = 1'b0;
    end
    // pins move only after an edge, like a clocked controller
    always @(posedge clk) begin
        pin_1 <= step_dn;
        pin_2 <= step_up | level;
    end
endmodule
